// ===== rtl/tpst_pkg.sv
// constants and types for the test pattern and self-test status block
package tpst_pkg;
    // -------------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_PATTERN  = 8'h04;
    localparam logic [7:0] OFS_PERIOD   = 8'h08;
    localparam logic [7:0] OFS_VT_CTRL  = 8'h0c;
    localparam logic [7:0] OFS_VT_DATA  = 8'h10;
    localparam logic [7:0] OFS_GAIN_ADR = 8'h14;
    localparam logic [7:0] OFS_GAIN_DAT = 8'h18;

    // -------------------------------------------------------------------
    // field layouts and reset values
    // -------------------------------------------------------------------
    localparam int          PAT_SEL_LSB     = 0;
    localparam int          TRIG_EXT_BIT    = 4;
    localparam logic [23:0] PERIOD_RESET    = 24'h004e20;
    localparam logic [11:0] GAIN_UNITY      = 12'h400;
    localparam int          GAIN_FRAC       = 10;
    localparam logic [31:0] STATUS_RESET    = 32'h00000000;
    localparam logic [31:0] STATUS_MASK     = 32'h00c77fff;
    localparam int          OVER_TEMP_BIT   = 10;

    // self-test status bit values
    localparam logic [31:0] ST_I2C          = 32'h00000001;
    localparam logic [31:0] ST_LOGIC_NOINIT = 32'h00000002;
    localparam logic [31:0] ST_LOGIC_NODONE = 32'h00000004;
    localparam logic [31:0] ST_SENSOR_SER   = 32'h00000008;
    localparam logic [31:0] ST_ECHO_BACK    = 32'h00000010;
    localparam logic [31:0] ST_NVM_TIMEOUT  = 32'h00000020;
    localparam logic [31:0] ST_NVM_ERROR    = 32'h00000040;
    localparam logic [31:0] ST_COMMON_MISS  = 32'h00000100;
    localparam logic [31:0] ST_FACTORY_MISS = 32'h00000200;
    localparam logic [31:0] ST_OVER_TEMP    = 32'h00000400;
    localparam logic [31:0] ST_SENSOR_PAT   = 32'h00000800;
    localparam logic [31:0] ST_USER_OFS     = 32'h00001000;
    localparam logic [31:0] ST_USER_GAIN    = 32'h00002000;
    localparam logic [31:0] ST_LINK_RETRY   = 32'h00004000;
    localparam logic [31:0] ST_USER_MISS    = 32'h00010000;
    localparam logic [31:0] ST_ADC_MISS     = 32'h00020000;
    localparam logic [31:0] ST_SCRIPT_MISS  = 32'h00040000;
    localparam logic [31:0] ST_FGAIN_MISS   = 32'h00400000;
    localparam logic [31:0] ST_FS_MISS      = 32'h00800000;

    // -------------------------------------------------------------------
    // pattern selection codes and pattern figures
    // -------------------------------------------------------------------
    localparam logic [2:0] PAT_OFF   = 3'h0;
    localparam logic [2:0] PAT_TAP   = 3'h1;
    localparam logic [2:0] PAT_HRAMP = 3'h2;
    localparam logic [2:0] PAT_VRAMP = 3'h3;
    localparam logic [2:0] PAT_DIAG  = 3'h4;
    localparam logic [2:0] PAT_USER  = 3'h5;

    localparam int          LINE_PIXELS = 16384;
    localparam logic [13:0] LAST_PIXEL  = 14'h3fff;
    localparam logic [7:0]  TAP_BASE    = 8'h40;
    localparam int          TAP_SHIFT   = 9;
    localparam int          TAP_STEP_SH = 2;
    localparam int          HRAMP_SHIFT = 5;
    localparam logic [7:0]  VRAMP_FIRST = 8'h05;
    localparam logic [7:0]  VRAMP_SECND = 8'h0c;
    localparam logic [7:0]  VRAMP_STEP  = 8'h03;
    localparam logic [7:0]  HALF_SCALE  = 8'h80;

    // -------------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } tpst_ahb_req_type;

    typedef struct packed {
        logic       valid;
        logic       sol;
        logic [7:0] data;
    } tpst_video_type;
endpackage : tpst_pkg

// ===== rtl/tpst_top.sv
// test pattern generator, line trigger and self-test status register
// -----------------------------------------------------------------------
// Summary of operation
// - patterns are eight-bit pixel values
// - software selects pattern, replacing sensor data
// - tap level 64 plus 4 per 512 pixels
// - two horizontal ramps, plus one per 32
// - vertical ramp 5, 12, then plus 3
// - diagonal is horizontal plus vertical ramp
// - half scale times uploaded per-pixel gain
// - status word 32 bits, bit0 control bus
// - logic init and done failure flags
// - sensor serial and echo-back failure flags
// - nonvolatile memory timeout and error flags
// - common, factory, user settings missing flags
// - over-temperature flag, may set any time
// - sensor pattern check failure flag
// - user offset and gain coefficients missing
// - link transmitter retry flag
// - reserved status bits except bit 7 stay zero
// - converter calibration and script missing flags
// - factory gain and file system missing
// - passing checks leave flags clear
// - internal mode uses line period, ignores triggers
// - external mode starts one line per trigger between lines
// - refresh request captures fresh voltage, temperature
// -----------------------------------------------------------------------
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
module tpst_top (
    // clock and reset
    input  wire logic                      CLK_I,
    input  wire logic                      RESET_I,
    // register bus
    input  wire tpst_pkg::tpst_ahb_req_type AHB_I,
    output logic [31:0]                    HRDATA_O,
    output logic                           HREADYOUT_O,
    output logic                           HRESP_O,
    // power-on self-test events
    input  wire logic                      POST_ACTIVE_I,
    input  wire logic [31:0]               POST_FAULT_I,
    // monitors and sensor data
    input  wire logic [15:0]               VOLT_I,
    input  wire logic [15:0]               TEMP_I,
    input  wire logic [7:0]                SENSOR_PIX_I,
    // link trigger and video
    input  wire logic                      LINE_TRIG_I,
    output tpst_pkg::tpst_video_type       VIDEO_O
);
    import tpst_pkg::*;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] status;
        logic [2:0]  pat_sel;
        logic        ext_trig;
        logic [23:0] period;
        logic [23:0] period_cnt;
        logic [13:0] gain_adr;
        logic [15:0] volt;
        logic [15:0] temp;
        logic        vt_fresh;
        logic        dp_valid;
        logic        dp_write;
        logic [7:0]  dp_addr;
        logic [31:0] rdata;
        logic        trig_s1;
        logic        trig_s2;
        logic        trig_s3;
        logic        active;
        logic [13:0] pix;
        logic [13:0] out_pix;
        logic [7:0]  vval;
        logic        vsecond;
        logic        vrestart;
        tpst_video_type video;
    } tpst_state_type;

    tpst_state_type st_r;
    tpst_state_type st_nxt;

    logic [11:0] gain_mem [LINE_PIXELS];
    logic [11:0] gain_rd;
    logic        gain_we;
    logic        line_start;
    logic        trig_edge;
    logic        int_fire;

    // -------------------------------------------------------------------
    // pattern arithmetic
    // -------------------------------------------------------------------
    function automatic logic [7:0] hramp(input logic [13:0] p);
        hramp = p[12:HRAMP_SHIFT];
    endfunction

    function automatic logic [7:0] tap_level(input logic [13:0] p);
        logic [7:0] blk;
        blk       = {3'h0, p[13:TAP_SHIFT]};
        tap_level = TAP_BASE + (blk << TAP_STEP_SH);
    endfunction

    function automatic logic [7:0] user_level(input logic [11:0] g);
        logic [19:0] prod;
        prod = {12'h000, HALF_SCALE} * {8'h00, g};
        if (prod[19:GAIN_FRAC] > 10'h0ff) begin
            user_level = 8'hff;
        end else begin
            user_level = prod[GAIN_FRAC+7:GAIN_FRAC];
        end
    endfunction

    function automatic logic [7:0] pattern_pix(
        input logic [2:0]  sel,
        input logic [13:0] p,
        input logic [7:0]  v,
        input logic [11:0] g,
        input logic [7:0]  sensor
    );
        unique case (sel)
            PAT_TAP:   pattern_pix = tap_level(p);
            PAT_HRAMP: pattern_pix = hramp(p);
            PAT_VRAMP: pattern_pix = v;
            PAT_DIAG:  pattern_pix = hramp(p) + v;
            PAT_USER:  pattern_pix = user_level(g);
            default:   pattern_pix = sensor;
        endcase
    endfunction

    assign gain_rd = gain_mem[st_r.pix];
    assign gain_we = st_r.dp_valid && st_r.dp_write &&
                     (st_r.dp_addr == OFS_GAIN_DAT);
    assign trig_edge = st_r.trig_s2 && !st_r.trig_s3;
    assign int_fire  = (st_r.period_cnt >= st_r.period - 24'h000001);
    // internal mode listens only to the period counter
    assign line_start = !st_r.active &&
                        (st_r.ext_trig ? trig_edge : int_fire);

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // bus address phase: zero wait, read data prepared now
        st_nxt.dp_valid = AHB_I.hsel && AHB_I.htrans[1] && AHB_I.hready;
        st_nxt.dp_write = AHB_I.hwrite;
        st_nxt.dp_addr  = AHB_I.haddr[7:0];
        if (st_nxt.dp_valid && !AHB_I.hwrite) begin
            unique case (AHB_I.haddr[7:0])
                OFS_STATUS:   st_nxt.rdata = st_r.status;
                OFS_PATTERN:  st_nxt.rdata = {27'h0, st_r.ext_trig,
                                              1'b0, st_r.pat_sel};
                OFS_PERIOD:   st_nxt.rdata = {8'h00, st_r.period};
                OFS_VT_CTRL:  st_nxt.rdata = {31'h0, st_r.vt_fresh};
                OFS_VT_DATA:  st_nxt.rdata = {st_r.temp, st_r.volt};
                OFS_GAIN_ADR: st_nxt.rdata = {18'h0, st_r.gain_adr};
                default:      st_nxt.rdata = 32'h00000000;
            endcase
        end

        // bus data phase writes; the status word takes none
        if (st_r.dp_valid && st_r.dp_write) begin
            unique case (st_r.dp_addr)
                OFS_PATTERN: begin
                    st_nxt.pat_sel  = AHB_I.hwdata[PAT_SEL_LSB+:3];
                    st_nxt.ext_trig = AHB_I.hwdata[TRIG_EXT_BIT];
                    st_nxt.vrestart = 1'b1;
                end
                OFS_PERIOD: begin
                    st_nxt.period = AHB_I.hwdata[23:0];
                end
                OFS_VT_CTRL: begin
                    st_nxt.volt     = VOLT_I;
                    st_nxt.temp     = TEMP_I;
                    st_nxt.vt_fresh = 1'b1;
                end
                OFS_GAIN_ADR: begin
                    st_nxt.gain_adr = AHB_I.hwdata[13:0];
                end
                OFS_GAIN_DAT: begin
                    st_nxt.gain_adr = st_r.gain_adr + 14'h0001;
                end
                default: begin
                end
            endcase
        end
        if (st_r.dp_valid && !st_r.dp_write &&
            st_r.dp_addr == OFS_VT_DATA) begin
            st_nxt.vt_fresh = 1'b0;
        end

        // self-test flags: events other than over-temperature latch during power-on only
        if (POST_ACTIVE_I) begin
            st_nxt.status = st_r.status | (POST_FAULT_I & STATUS_MASK);
        end
        // over-temperature may appear at any time
        if (POST_FAULT_I[OVER_TEMP_BIT]) begin
            st_nxt.status[OVER_TEMP_BIT] = 1'b1;
        end
        // reserved bits other than bit 7 never set
        st_nxt.status = st_nxt.status & STATUS_MASK;

        // line trigger synchroniser
        st_nxt.trig_s1 = LINE_TRIG_I;
        st_nxt.trig_s2 = st_r.trig_s1;
        st_nxt.trig_s3 = st_r.trig_s2;

        // internal line period counter
        if (int_fire) begin
            st_nxt.period_cnt = 24'h000000;
        end else begin
            st_nxt.period_cnt = st_r.period_cnt + 24'h000001;
        end

        // pixel emission
        st_nxt.video.valid = st_r.active;
        st_nxt.video.sol   = st_r.active && (st_r.pix == 14'h0000);
        st_nxt.video.data  = st_r.active ?
            pattern_pix(st_r.pat_sel, st_r.pix, st_r.vval, gain_rd,
                        SENSOR_PIX_I) : 8'h00;
        st_nxt.out_pix = st_r.pix;
        if (st_r.active) begin
            st_nxt.pix = st_r.pix + 14'h0001;
            if (st_r.pix == LAST_PIXEL) begin
                st_nxt.active = 1'b0;
            end
        end

        // line start: horizontal restarts, vertical steps, or restarts at 5 after a pattern write
        if (line_start) begin
            st_nxt.active = 1'b1;
            st_nxt.pix    = 14'h0000;
            if (st_r.vrestart) begin
                st_nxt.vval     = VRAMP_FIRST;
                st_nxt.vsecond  = 1'b1;
                st_nxt.vrestart = 1'b0;
            end else if (st_r.vsecond) begin
                st_nxt.vval    = VRAMP_SECND;
                st_nxt.vsecond = 1'b0;
            end else begin
                st_nxt.vval = st_r.vval + VRAMP_STEP;
            end
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            st_r          <= '0;
            st_r.status   <= STATUS_RESET;
            st_r.period   <= PERIOD_RESET;
            st_r.vrestart <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // gain coefficient upload
    always_ff @(posedge CLK_I) begin
        if (gain_we) begin
            gain_mem[st_r.gain_adr] <= AHB_I.hwdata[11:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            HRDATA_O    <= 32'h00000000;
            VIDEO_O     <= '0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            HRDATA_O    <= st_nxt.rdata;
            VIDEO_O     <= st_nxt.video;
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    sequence s_restart_line;
        line_start && st_r.vrestart;
    endsequence

    sequence s_plain_line;
        line_start && !st_r.vrestart && !st_r.vsecond;
    endsequence

    chk_status_held: assert property (
        !POST_ACTIVE_I |=> ((st_r.status & ~ST_OVER_TEMP) ==
                            $past(st_r.status & ~ST_OVER_TEMP)))
        else $error("status changed outside power-on");

    chk_status_rsvd: assert property (
        (st_r.status & ~STATUS_MASK) == 32'h00000000)
        else $error("reserved status bit set");

    chk_fault_latch: assert property (
        POST_ACTIVE_I |=> ((st_r.status & $past(POST_FAULT_I) &
                            STATUS_MASK) ==
                           ($past(POST_FAULT_I) & STATUS_MASK)))
        else $error("power-on fault not latched");

    chk_over_temp: assert property (
        POST_FAULT_I[OVER_TEMP_BIT] |=> st_r.status[OVER_TEMP_BIT]
                                        [*3])
        else $error("over-temperature flag lost");

    chk_tap_level: assert property (
        st_r.video.valid && $past(st_r.pat_sel) == PAT_TAP |->
        st_r.video.data == tap_level(st_r.out_pix))
        else $error("tap level wrong");

    chk_hramp_val: assert property (
        st_r.video.valid && $past(st_r.pat_sel) == PAT_HRAMP |->
        st_r.video.data == st_r.out_pix[12:HRAMP_SHIFT])
        else $error("horizontal ramp wrong");

    chk_vramp_first: assert property (
        s_restart_line |=> st_r.vval == VRAMP_FIRST && st_r.vsecond)
        else $error("vertical ramp did not restart at 5");

    chk_vramp_step: assert property (
        s_plain_line |=> st_r.vval == $past(st_r.vval) + VRAMP_STEP)
        else $error("vertical ramp step wrong");

    chk_ext_start: assert property (
        st_r.ext_trig && trig_edge && !st_r.active |=>
        st_r.active ##1 st_r.video.sol && st_r.video.valid)
        else $error("trigger did not start a line");

    chk_int_ignore: assert property (
        !st_r.ext_trig && !int_fire && !st_r.active |=> !st_r.active)
        else $error("line started without period in internal mode");

    chk_vt_fresh: assert property (
        st_r.dp_valid && st_r.dp_write && st_r.dp_addr == OFS_VT_CTRL
        |=> st_r.volt == $past(VOLT_I) && st_r.temp == $past(TEMP_I))
        else $error("monitor refresh not captured");
endmodule : tpst_top

// ===== test/tpst_grabber.sv
// frame grabber model: line trigger source and video line capture
module tpst_grabber
    import tpst_pkg::*;
(
    // clock
    input  wire logic           clk_i,
    // video from the block
    input  wire tpst_video_type video_i,
    // line trigger towards the block
    output logic                trig_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] pix [LINE_PIXELS];
    int         cnt   = 0;
    int         lines = 0;
    int         k;
    logic       was_v = 1'b0;
    time        sol_t [2];

    initial trig_o = 1'b0;

    // -------------------------------------------------------------------
    // capture: pixel index restarts on the start-of-line flag
    // -------------------------------------------------------------------
    always @(posedge clk_i) begin
        k = (video_i.sol === 1'b1) ? 0 : cnt;
        if (video_i.valid === 1'b1) begin
            if (k < LINE_PIXELS) begin
                pix[k] <= video_i.data;
            end
            cnt <= k + 1;
            if (video_i.sol === 1'b1) begin
                sol_t <= '{sol_t[1], $time};
            end
        end
        if (video_i.valid !== 1'b1 && was_v) begin
            lines <= lines + 1;
        end
        was_v <= (video_i.valid === 1'b1);
    end

    // one pulse held four clocks so the synchroniser always sees it
    task automatic fire();
        @(posedge clk_i);
        trig_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        trig_o <= 1'b0;
    endtask
endmodule // tpst_grabber

// ===== test/tb_top.sv
// self-checking testbench for the test pattern and self-test block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tpst_pkg::*;

    localparam int          PER_LINE = 16400;
    localparam logic [31:0] CODES [18] = '{
        32'h00000001, 32'h00000002, 32'h00000004, 32'h00000008,
        32'h00000010, 32'h00000020, 32'h00000040, 32'h00000100,
        32'h00000200, 32'h00000800, 32'h00001000, 32'h00002000,
        32'h00004000, 32'h00010000, 32'h00020000, 32'h00040000,
        32'h00400000, 32'h00800000};
    localparam logic [11:0] GAINS [5] = '{12'h400, 12'h200, 12'h800,
                                          12'h000, 12'h0c0};
    localparam logic [7:0]  GPIX [5]  = '{8'h80, 8'h40, 8'hff, 8'h00,
                                          8'h18};

    logic             clk = 1'b0;
    logic             rst;
    tpst_ahb_req_type mst;
    tpst_ahb_req_type bus;
    logic [31:0]      hrdata;
    logic             hready;
    logic             hresp;
    logic             post_act;
    logic [31:0]      post_flt;
    logic [15:0]      volt;
    logic [15:0]      temp;
    logic             trig;
    tpst_video_type   video;
    logic [31:0]      acc;
    int               failures = 0;
    int               checks = 0;

    // the master's own hready field is replaced by the slave's answer
    assign bus = {mst[71:1], hready};

    always #4 clk = ~clk;

    tpst_top DUT (
        .CLK_I        (clk),
        .RESET_I      (rst),
        .AHB_I        (bus),
        .HRDATA_O     (hrdata),
        .HREADYOUT_O  (hready),
        .HRESP_O      (hresp),
        .POST_ACTIVE_I(post_act),
        .POST_FAULT_I (post_flt),
        .VOLT_I       (volt),
        .TEMP_I       (temp),
        .SENSOR_PIX_I (8'ha5),
        .LINE_TRIG_I  (trig),
        .VIDEO_O      (video)
    );

    tpst_grabber FG (
        .clk_i  (clk),
        .video_i(video),
        .trig_o (trig)
    );

    // -------------------------------------------------------------------
    // checking and bus tasks
    // -------------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic give_up();
        failures++;
        close_out();
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk);
        mst.hsel   <= 1'b1;
        mst.htrans <= 2'b10;
        mst.haddr  <= {24'h000000, a};
        mst.hwrite <= wr;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (hready !== 1'b1 && n < 64);
            if (n >= 64) give_up();
            if (ph == 0) begin
                mst.hsel   <= 1'b0;
                mst.htrans <= 2'b00;
                mst.hwdata <= wd;
            end
        end
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask

    task automatic pulse(input logic [31:0] v);
        @(posedge clk);
        post_flt <= v;
        @(posedge clk);
        post_flt <= 32'h0;
    endtask

    task automatic wait_lines(input int want);
        int n;
        n = 0;
        while (FG.lines < want && n < 40000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40000) give_up();
    endtask

    task automatic wait_pix(input int p);
        int n;
        n = 0;
        while (!(FG.was_v && FG.cnt >= p) && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000) give_up();
    endtask

    function automatic logic [7:0] exp_pix(input logic [2:0] sel,
                                           input int k, input int v);
        case (sel)
            PAT_TAP:  return 8'(64 + 4 * (k >> 9));
            PAT_DIAG: return 8'(((k % 8192) >> 5) + v);
            default:  return 8'(v);
        endcase
    endfunction

    task automatic line_chk(input logic [2:0] sel, input int v);
        chk(FG.cnt, LINE_PIXELS);
        for (int k = 0; k < LINE_PIXELS; k++) begin
            chk({24'h0, FG.pix[k]}, {24'h0, exp_pix(sel, k, v)});
        end
    endtask

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        mst = '0;
        mst.hsize = 3'h2;
        rst = 1'b1;
        post_act = 1'b1;
        post_flt = 32'h0;
        volt = 16'h1234;
        temp = 16'h0abc;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFS_STATUS, 32'h0);
        // short period starts line one early, then the real period
        wr(OFS_PATTERN, {29'h0, PAT_VRAMP});
        wr(OFS_PERIOD, 32'd40);
        repeat (60) @(posedge clk);
        wr(OFS_PERIOD, PER_LINE);
        for (int l = 1; l <= 3; l++) begin
            wait_lines(l);
            line_chk(PAT_VRAMP, (l == 1) ? 5 : 3 * l + 6);
            if (l == 2) FG.fire();
        end
        chk(32'(FG.sol_t[1] - FG.sol_t[0]), PER_LINE * 8);
        wr(OFS_PATTERN, {27'h0, 2'b10, PAT_TAP});
        FG.fire();
        wait_lines(4);
        line_chk(PAT_TAP, 0);
        wr(OFS_PATTERN, {27'h0, 2'b10, PAT_DIAG});
        FG.fire();
        repeat (20) @(posedge clk);
        FG.fire();
        wait_lines(5);
        line_chk(PAT_DIAG, 5);
        repeat (40) @(posedge clk);
        chk({31'h0, video.valid}, 32'h0);
        wr(OFS_GAIN_ADR, 32'h0);
        foreach (GAINS[i]) wr(OFS_GAIN_DAT, {20'h0, GAINS[i]});
        wr(OFS_PATTERN, {27'h0, 2'b10, PAT_USER});
        FG.fire();
        // mid-line switches: user head, horizontal ramp, then sensor
        wait_pix(100);
        wr(OFS_PATTERN, {27'h0, 2'b10, PAT_HRAMP});
        wait_pix(8300);
        wr(OFS_PATTERN, {27'h0, 2'b10, PAT_OFF});
        wait_lines(6);
        foreach (GPIX[i]) chk({24'h0, FG.pix[i]}, {24'h0, GPIX[i]});
        for (int k = 200; k < 8192; k++) begin
            chk({24'h0, FG.pix[k]}, {24'h0, exp_pix(PAT_DIAG, k, 0)});
        end
        for (int k = 8400; k < LINE_PIXELS; k++) begin
            chk({24'h0, FG.pix[k]}, 32'h000000a5);
        end
        // self-test flags accumulate one code at a time
        acc = 32'h0;
        foreach (CODES[i]) begin
            pulse(CODES[i]);
            acc = acc | CODES[i];
            rd_chk(OFS_STATUS, acc);
        end
        pulse(32'hff388000);
        rd_chk(OFS_STATUS, 32'h00c77b7f);
        post_act <= 1'b0;
        pulse(32'hffffffff);
        rd_chk(OFS_STATUS, 32'h00c77f7f);
        wr(OFS_STATUS, 32'h0);
        rd_chk(OFS_STATUS, 32'h00c77f7f);
        rd_chk(8'h40, 32'h0);
        wr(OFS_VT_CTRL, 32'h1);
        rd_chk(OFS_VT_CTRL, 32'h1);
        rd_chk(OFS_VT_DATA, 32'h0abc1234);
        rd_chk(OFS_VT_CTRL, 32'h0);
        volt <= 16'h0777;
        wr(OFS_VT_CTRL, 32'h1);
        rd_chk(OFS_VT_DATA, 32'h0abc0777);
        close_out();
    end
endmodule // tb_top
